/* sim/pmirq_evt_src.sv */
// match event source in place of the pwm unit and timer
// assumes the bench calls pulse just after a clk_sys edge
`timescale 1ns/1ps
module pmirq_evt_src
    import pmirq_pkg::*;
(
    input wire logic clk_sys,
    output pmirq_evt_t evt
);
    initial evt = '0;
    // one-cycle pulse, as a compare unit gives per match
    task automatic pulse(input logic [5:0] v);
        evt <= v;
        @(posedge clk_sys);
        evt <= '0;
    endtask
endmodule

/* sim/pmirq_top_sva.sv */
// port checker for the pwm match interrupt slice
// assumes pmirq_pkg is compiled first
`timescale 1ns/1ps
module pmirq_chk
    import pmirq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire pmirq_apb_req_t apb_req,
    input wire pmirq_apb_rsp_t apb_rsp,
    input wire pmirq_evt_t evt,
    input wire logic [3:0] pwm_irq_req,
    input wire logic [1:0] timer2_irq_req,
    input wire logic irq
);
    // ==========
    // a write may raise a request as well as an event
    wire acc = apb_req.psel && apb_req.penable;
    wire wr = acc && apb_req.pwrite;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_rd_tmr;
        acc && !apb_req.pwrite && apb_req.paddr == 12'h004;
    endsequence
    a_tmr_unimpl: assert property (s_rd_tmr |-> apb_rsp.prdata[7:6] == 2'h0) else $error("t");
    a_unmapped_err: assert property (acc && apb_req.paddr[11:4] != 8'h00 |-> apb_rsp.pslverr)
        else $error("e");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> !irq && pwm_irq_req == 4'h0
        && timer2_irq_req == 2'h0) else $error("r");
    a_period_cause: assert property ($rose(pwm_irq_req[3]) |-> $past(evt.period_match || wr))
        else $error("p");
    a_ch2_cause: assert property ($rose(pwm_irq_req[2]) |-> $past(evt.ch2_duty_match || wr))
        else $error("c2");
    a_ch1_cause: assert property ($rose(pwm_irq_req[1]) |-> $past(evt.ch1_duty_match || wr))
        else $error("c1");
    a_ch0_holds: assert property (pwm_irq_req[0] && !wr |=> pwm_irq_req[0]) else $error("c0");
    a_irq_cause: assert property ($rose(irq) |-> $past(|evt || wr)) else $error("i");
endmodule

bind pmirq_top pmirq_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .evt(evt), .pwm_irq_req(pwm_irq_req), .timer2_irq_req(timer2_irq_req),
    .irq(irq));

/* sim/tb_top.sv */
// self-checking bench for the pwm match interrupt slice
// assumes package, design, checker and event source compiled first
`timescale 1ns/1ps
module tb_top;
    import pmirq_pkg::*;
    logic clk_sys = 0;
    logic sys_rst = 1;
    pmirq_apb_req_t req = '0;
    pmirq_apb_rsp_t rsp;
    pmirq_evt_t evt;
    logic [3:0] preq;
    logic [1:0] treq;
    logic irq, er;
    logic [31:0] rd, w;
    logic [5:0] v;
    int fail_count = 0;
    int comparisons = 0;
    int ex[4] = '{0, 0, 0, 0};
    int keep[4] = '{255, 'h33, 0, 'h3f};
    always #2.5 clk_sys = ~clk_sys;
    pmirq_evt_src src (.clk_sys(clk_sys), .evt(evt));
    pmirq_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
        .evt(evt), .pwm_irq_req(preq), .timer2_irq_req(treq), .irq(irq));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // setup, then access until pready; bounded so a hang ends the run
    task automatic apb(input logic wt, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wt, paddr: a, pwdata: {24'h0, d}};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
        if (rsp.pready !== 1'b1) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic rd_all();
        for (int i = 0; i < 4; i++) begin
            apb(0, 12'(i * 4), 8'h00);
            chk("register", ex[i], rd);
            chk("pslverr", 0, er);
        end
    endtask
    initial begin
        void'($urandom(36));
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_all();
        apb(0, 12'h7f0, 8'h00);
        chk("pslverr", 1, er);
        $display("test reset done");
        // random enables, masks, status clears and events
        repeat (40) begin
            for (int i = 0; i < 4; i++) begin
                w = $urandom;
                apb(1, 12'(i * 4), w[7:0]);
                if (i == 2) ex[2] &= ~w[7:0];
                else ex[i] = w[7:0] & keep[i];
            end
            apb(1, 12'h7f0, 8'hff);
            v = 6'($urandom);
            src.pulse(v);
            ex[0] |= v[5:2] << 4;
            ex[1] |= v[1:0] << 4;
            ex[2] |= v[5:2] | (v[1:0] << 4);
            @(posedge clk_sys);
            chk("pwm_irq_req", (ex[0] >> 4) & ex[0] & 15, preq);
            chk("timer2_irq_req", (ex[1] >> 4) & ex[1] & 3, treq);
            chk("irq", (ex[2] & ex[3]) != 0, irq);
            rd_all();
        end
        $display("test events done");
        give_verdict();
    end
endmodule

/* src/pmirq_defs.svh */
// register offsets, field positions and reset values of the match interrupt slice
// assumes inclusion by bare name from the package; the design module uses its macros without including it
`ifndef PMIRQ_DEFS_SVH
`define PMIRQ_DEFS_SVH

// ==================================================
// register byte offsets on the apb bus
`define PMIRQ_OFF_CTRL 12'h000
`define PMIRQ_OFF_TMR 12'h004
`define PMIRQ_OFF_STAT 12'h008
`define PMIRQ_OFF_MASK 12'h00c

// ==================================================
// field positions of the pwm control register
`define PMIRQ_B_PF 7
`define PMIRQ_B_D2F 6
`define PMIRQ_B_D1F 5
`define PMIRQ_B_D0F 4
`define PMIRQ_B_PE 3
`define PMIRQ_B_D2E 2
`define PMIRQ_B_D1E 1
`define PMIRQ_B_D0E 0

// ==================================================
// field positions of the timer register
`define PMIRQ_B_TAF 5
`define PMIRQ_B_TPF 4
`define PMIRQ_B_TAE 1
`define PMIRQ_B_TPE 0
`define PMIRQ_TMR_IMPL 8'h33

// ==================================================
// reset values
`define PMIRQ_RST_CTRL 8'h00
`define PMIRQ_RST_TMR 8'h00
`define PMIRQ_RST_STAT 8'h00
`define PMIRQ_RST_MASK 8'h00

`endif

/* src/pmirq_pkg.sv */
// types shared by the match interrupt slice
// assumes pmirq_defs.svh is on the include path
package pmirq_pkg;
    `include "pmirq_defs.svh"

    // ==================================================
    // apb request and answer carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pmirq_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pmirq_apb_rsp_t;

    // ==================================================
    // match events from the pwm unit and timer
    typedef struct packed {
        logic period_match;
        logic ch2_duty_match;
        logic ch1_duty_match;
        logic ch0_duty_match;
        logic timer2_cmp_a;
        logic timer2_cmp_p;
    } pmirq_evt_t;
endpackage

/* src/pmirq_top.sv */
// pwm match and timer-two interrupt flag slice with an apb register port
// assumes match events are single-cycle pulses on clk_sys from logic on this clock
//
// Summary of operation
// - bit 5 holds channel one duty match request flag, 1 means pending
// - bit 4 holds channel zero duty match request flag, 1 means pending
// - bit 3 enables the period match interrupt
// - bit 2 enables the channel two duty match interrupt
// - bit 1 enables the channel one duty match interrupt
// - bit 0 enables the channel zero duty match interrupt
// - timer register bits 7 and 6 are unimplemented and read zero
// - bit 7 holds the period match request flag
// - bit 6 holds the channel two duty match request flag
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps

module pmirq_top
    import pmirq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire pmirq_apb_req_t apb_req,
    output pmirq_apb_rsp_t apb_rsp,
    input wire pmirq_evt_t evt,
    output logic [3:0] pwm_irq_req,
    output logic [1:0] timer2_irq_req,
    output logic irq
);

    // ==================================================
    // state
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] tmr_reg;
    logic [7:0] tmr_next;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    pmirq_apb_rsp_t rsp_reg;
    pmirq_apb_rsp_t rsp_next;

    // ==================================================
    // bus decode
    wire access_w = apb_req.psel && apb_req.penable;
    wire wr_w = access_w && apb_req.pwrite;
    wire [7:0] wd_w = apb_req.pwdata[7:0];
    wire sel_ctrl_w = apb_req.paddr == `PMIRQ_OFF_CTRL;
    wire sel_tmr_w = apb_req.paddr == `PMIRQ_OFF_TMR;
    wire sel_stat_w = apb_req.paddr == `PMIRQ_OFF_STAT;
    wire sel_mask_w = apb_req.paddr == `PMIRQ_OFF_MASK;
    wire mapped_w = sel_ctrl_w | sel_tmr_w | sel_stat_w | sel_mask_w;

    // ==================================================
    // event set vectors, laid out as the control and timer flag fields
    wire [7:0] pwm_set_w = {evt.period_match, evt.ch2_duty_match,
                            evt.ch1_duty_match, evt.ch0_duty_match, 4'h0};
    wire [7:0] tmr_set_w = {2'h0, evt.timer2_cmp_a, evt.timer2_cmp_p, 4'h0};
    // sticky status: pwm events low nibble, timer events bits 5:4
    wire [7:0] evt_stat_w = {2'h0, tmr_set_w[5:4], pwm_set_w[7:4]};

    // flag write: software writes the value, but a same-cycle event wins
    function automatic logic [7:0] upd_flags(input logic [7:0] cur, input logic [7:0] set,
                                             input logic we, input logic [7:0] wd,
                                             input logic [7:0] impl);
        logic [7:0] v;
        v = we ? wd : cur;
        upd_flags = (v | set) & impl;
    endfunction

    // ==================================================
    // next-state for the pwm control register
    assign ctrl_next = upd_flags(ctrl_reg, pwm_set_w, wr_w && sel_ctrl_w, wd_w,
                                 8'hff);

    // timer register keeps only its implemented bits
    assign tmr_next = upd_flags(tmr_reg, tmr_set_w, wr_w && sel_tmr_w, wd_w,
                                `PMIRQ_TMR_IMPL);

    // status is write-one-to-clear; set beats clear
    assign stat_next = (stat_reg & ~((wr_w && sel_stat_w) ? wd_w : 8'h00))
                       | evt_stat_w;

    // mask only covers the six implemented status bits
    assign mask_next = (wr_w && sel_mask_w) ? (wd_w & 8'h3f) : mask_reg;

    // ==================================================
    // read mux; unmapped addresses answer with an error and zero data
    wire [7:0] rd_w = sel_ctrl_w ? ctrl_reg :
                      sel_tmr_w ? tmr_reg :
                      sel_stat_w ? stat_reg :
                      sel_mask_w ? mask_reg : 8'h00;

    // zero wait states, so pready is simply high in every access phase
    always_comb begin
        rsp_next.pready = 1'b1;
        rsp_next.pslverr = 1'b0;
        rsp_next.prdata = 32'h0000_0000;
        if (apb_req.psel && !apb_req.penable) begin
            rsp_next.pslverr = !mapped_w;
            rsp_next.prdata = {24'h00_0000, rd_w};
        end else if (access_w) begin
            rsp_next.pslverr = rsp_reg.pslverr;
            rsp_next.prdata = rsp_reg.prdata;
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_reg <= `PMIRQ_RST_CTRL;
            tmr_reg <= `PMIRQ_RST_TMR;
            stat_reg <= `PMIRQ_RST_STAT;
            mask_reg <= `PMIRQ_RST_MASK;
        end else begin
            ctrl_reg <= ctrl_next;
            tmr_reg <= tmr_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
        end
    end

    // read data captured in setup, so it stands through the access phase
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // ==================================================
    // outputs
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access_w && rsp_reg.pslverr;
    assign apb_rsp.prdata = rsp_reg.prdata;

    // gated requests: flag and its enable both set
    assign pwm_irq_req = ctrl_reg[7:4] & ctrl_reg[3:0];
    assign timer2_irq_req = tmr_reg[5:4] & tmr_reg[1:0];

    // summary line from sticky status and mask
    assign irq = |(stat_reg & mask_reg);

endmodule
